/* verilog/gtmr_top.sv */
// general timer: apb registers, 16-bit counter, events and flags
`timescale 1ns/10ps
module gtmr_top
(
   input wire logic clock_in,
   input wire logic reset_n_in,
   input wire logic clk_en_in,
   input wire logic psel_in,
   input wire logic penable_in,
   input wire logic pwrite_in,
   input wire logic [7:0] paddr_in,
   input wire logic [31:0] pwdata_in,
   output logic [31:0] prdata_out,
   output logic pready_out,
   output logic pslverr_out,
   input wire logic event_in,
   input wire logic tick_in,
   input wire logic debug_halt_in,
   output logic ovf_irq_out,
   output logic [gtmr_pkg::NCH-1:0] cmp_irq_out
);
   import gtmr_pkg::*;

   // ----------------------------------------
   // state
   // ----------------------------------------
   logic en_r;
   logic [2:0] wgm_r;
   logic lock_r;
   logic dir_r;
   logic ev_en_r;
   logic [1:0] action_r;
   logic ovf_ie_r;
   logic [NCH-1:0] cmp_ie_r;
   logic ovf_f_r;
   logic [NCH-1:0] cmp_f_r;
   logic dbg_r;
   logic [7:0] temp_r;
   logic [15:0] cnt_r;
   logic [15:0] per_r;
   logic [15:0] per_buf_r;
   logic per_valid_r;
   logic ev_q_r;
   logic upd_q_r;
   logic got_r;
   logic [31:0] prdata_r;

   logic [5:0] idx;
   logic [5:0] base;
   logic [7:0] wb;
   logic [15:0] wval;
   logic wr;
   logic lo_wr;
   logic hi_wr;
   logic rd_cap;
   logic wide;
   logic map_ok;
   logic [15:0] rd_w;
   logic [7:0] rd_b;
   logic [NCH-1:0] cmp_bv;
   logic [NCH-1:0] cmp_hit;
   logic [15:0] cmp_val [NCH];
   logic [15:0] cmp_buf [NCH];

   logic run;
   logic step;
   logic down;
   logic dual;
   logic [15:0] top;
   logic [15:0] cnt_nxt;
   logic dir_nxt;
   logic top_ev;
   logic bot_ev;
   logic ovf_ev;
   logic upd_ev;
   logic xfer;
   logic cnt_wr;

   // ----------------------------------------
   // apb decode
   // ----------------------------------------
   assign idx = paddr_in[7:2];
   assign base = idx & IX_WIDE_MASK;
   assign wb = pwdata_in[7:0];
   assign wval = {temp_r, wb};
   assign wide = (base == IX_CNT) || (base == IX_PER)
      || (base == IX_PER_BUF)
      || (base >= IX_CMP && base < IX_CMP + 6'(2 * NCH))
      || (base >= IX_CMPBUF && base < IX_CMPBUF + 6'(2 * NCH));
   // no wait state: read data is caught once, before pready
   assign pready_out = psel_in && penable_in && got_r && clk_en_in;
   assign pslverr_out = pready_out && !map_ok;
   assign wr = pready_out && pwrite_in && map_ok;
   assign lo_wr = wr && wide && !idx[0];
   assign hi_wr = wr && wide && idx[0];
   assign rd_cap = clk_en_in && psel_in && !got_r;
   assign cnt_wr = lo_wr && (base == IX_CNT);
   assign prdata_out = prdata_r;

   always_ff @(posedge clock_in or negedge reset_n_in)
   begin
      if (!reset_n_in)
      begin
         got_r <= 1'b0;
      end
      else if (clk_en_in)
      begin
         got_r <= psel_in && !pready_out;
      end
   end

   // ----------------------------------------
   // read mux
   // ----------------------------------------
   always_comb
   begin
      rd_w = WIDE_RST;
      if (base == IX_CNT)
         rd_w = cnt_r;
      else if (base == IX_PER)
         rd_w = per_r;
      else if (base == IX_PER_BUF)
         rd_w = per_buf_r;
      for (int i = 0; i < NCH; i++)
      begin
         if (base == IX_CMP + 6'(2 * i))
            rd_w = cmp_val[i];
         if (base == IX_CMPBUF + 6'(2 * i))
            rd_w = cmp_buf[i];
      end
   end

   always_comb
   begin
      map_ok = 1'b1;
      rd_b = 8'h00;
      unique case (idx)
         IX_CTRLA: rd_b = {4'h0, wgm_r, en_r};
         IX_CTRLE: rd_b = {6'h00, lock_r, dir_r};
         IX_BVCLR, IX_BVSET: rd_b = {4'h0, cmp_bv, per_valid_r};
         IX_EVENT: rd_b = {5'h00, action_r, ev_en_r};
         IX_INTEN: rd_b = {1'b0, cmp_ie_r, 3'h0, ovf_ie_r};
         IX_FLAGS: rd_b = {1'b0, cmp_f_r, 3'h0, ovf_f_r};
         IX_DBG: rd_b = {7'h00, dbg_r};
         IX_TEMP: rd_b = temp_r;
         default:
         begin
            map_ok = wide;
            // high byte comes from the latched copy
            rd_b = !wide ? 8'h00 : (idx[0] ? temp_r : rd_w[7:0]);
         end
      endcase
   end

   always_ff @(posedge clock_in or negedge reset_n_in)
   begin
      if (!reset_n_in)
      begin
         prdata_r <= 32'h0000_0000;
      end
      else if (rd_cap && !pwrite_in)
      begin
         prdata_r <= {24'h00_0000, rd_b};
      end
   end

   // ----------------------------------------
   // shared temporary byte
   // ----------------------------------------
   // one byte shared by all wide registers
   always_ff @(posedge clock_in or negedge reset_n_in)
   begin
      if (!reset_n_in)
      begin
         temp_r <= 8'h00;
      end
      else if (clk_en_in)
      begin
         if (hi_wr || (wr && idx == IX_TEMP))
            temp_r <= wb;
         else if (rd_cap && !pwrite_in && wide && !idx[0])
            temp_r <= rd_w[15:8];
      end
   end

   // ----------------------------------------
   // control registers
   // ----------------------------------------
   always_ff @(posedge clock_in or negedge reset_n_in)
   begin
      if (!reset_n_in)
      begin
         en_r <= 1'b0;
         wgm_r <= WG_NORMAL;
         lock_r <= 1'b0;
         ev_en_r <= 1'b0;
         action_r <= ACT_RISING;
         ovf_ie_r <= 1'b0;
         cmp_ie_r <= '0;
         dbg_r <= 1'b0;
      end
      else if (clk_en_in && wr)
      begin
         if (idx == IX_CTRLA)
         begin
            en_r <= wb[B_EN];
            wgm_r <= wb[B_WGM +: 3];
         end
         if (idx == IX_CTRLE)
            lock_r <= wb[B_LOCK];
         if (idx == IX_EVENT)
         begin
            ev_en_r <= wb[B_EV_EN];
            action_r <= wb[B_ACTION +: 2];
         end
         if (idx == IX_INTEN)
         begin
            ovf_ie_r <= wb[B_OVERFLOW];
            cmp_ie_r <= wb[B_CMPF +: NCH];
         end
         if (idx == IX_DBG)
            dbg_r <= wb[B_RUN_BREAK];
      end
   end

   // hardware drives direction, a software write overrides
   always_ff @(posedge clock_in or negedge reset_n_in)
   begin
      if (!reset_n_in)
         dir_r <= 1'b0;
      else if (clk_en_in)
         dir_r <= (wr && idx == IX_CTRLE) ? wb[B_DIR] : dir_nxt;
   end

   // ----------------------------------------
   // counting
   // ----------------------------------------
   // break halts the timer and ignores events
   assign run = en_r && (dbg_r || !debug_halt_in);
   assign dual = (wgm_r == WG_DSTOP) || (wgm_r == WG_DSBOTH)
      || (wgm_r == WG_DSBOTTOM);
   // frequency mode takes top from channel 0
   assign top = (wgm_r == WG_FRQ) ? cmp_val[0] : per_r;

   always_comb
   begin
      step = 1'b0;
      down = dir_r;
      // event drives counting only when enabled
      if (ev_en_r)
      begin
         unique case (action_r)
            ACT_RISING: step = event_in && !ev_q_r;
            ACT_BOTH: step = event_in ^ ev_q_r;
            ACT_GATED: step = tick_in && event_in;
            ACT_UPDOWN:
            begin
               step = tick_in;
               down = event_in;
            end
         endcase
      end
      else
         step = tick_in;
      step = step && run;
   end

   // next count, direction and top/bottom events
   always_comb
   begin
      cnt_nxt = cnt_r;
      dir_nxt = down;
      top_ev = 1'b0;
      bot_ev = 1'b0;
      if (step)
      begin
         if (down)
         begin
            cnt_nxt = cnt_r - CNT_ONE;
            if (cnt_r == WIDE_RST)
            begin
               bot_ev = 1'b1;
               top_ev = !dual;
               cnt_nxt = dual ? CNT_ONE : top;
               dir_nxt = !dual;
            end
         end
         else
         begin
            cnt_nxt = cnt_r + CNT_ONE;
            if (cnt_r == top)
            begin
               top_ev = 1'b1;
               bot_ev = !dual;
               cnt_nxt = dual ? cnt_r - CNT_ONE : WIDE_RST;
               dir_nxt = dual;
            end
         end
      end
   end

   always_comb
   begin
      ovf_ev = 1'b0;
      upd_ev = 1'b0;
      case (wgm_r)
         WG_NORMAL, WG_FRQ:
         begin
            ovf_ev = top_ev;
            upd_ev = top_ev;
         end
         WG_SINGLE, WG_DSBOTTOM:
         begin
            ovf_ev = bot_ev;
            upd_ev = bot_ev;
         end
         WG_DSTOP:
         begin
            ovf_ev = top_ev;
            upd_ev = bot_ev;
         end
         WG_DSBOTH:
         begin
            ovf_ev = top_ev || bot_ev;
            upd_ev = bot_ev;
         end
         default:
         begin
            ovf_ev = 1'b0;
            upd_ev = 1'b0;
         end
      endcase
   end

   assign xfer = upd_ev && !lock_r;

   // software write beats the hardware count
   always_ff @(posedge clock_in or negedge reset_n_in)
   begin
      if (!reset_n_in)
      begin
         cnt_r <= WIDE_RST;
         ev_q_r <= 1'b0;
         upd_q_r <= 1'b0;
      end
      else if (clk_en_in)
      begin
         cnt_r <= cnt_wr ? wval : cnt_nxt;
         ev_q_r <= event_in;
         upd_q_r <= step && !cnt_wr;
      end
   end

   // ----------------------------------------
   // period and its buffer
   // ----------------------------------------
   always_ff @(posedge clock_in or negedge reset_n_in)
   begin
      if (!reset_n_in)
      begin
         per_r <= PER_RST;
         per_buf_r <= PER_RST;
      end
      else if (clk_en_in)
      begin
         if (lo_wr && base == IX_PER)
            per_r <= wval;
         else if (xfer)
            per_r <= per_buf_r;
         if (lo_wr && base == IX_PER_BUF)
            per_buf_r <= wval;
      end
   end

   // a fresh buffer write wins over clears
   always_ff @(posedge clock_in or negedge reset_n_in)
   begin
      if (!reset_n_in)
         per_valid_r <= 1'b0;
      else if (clk_en_in)
      begin
         if ((lo_wr && base == IX_PER_BUF)
            || (wr && idx == IX_BVSET && wb[B_PER_VALID]))
            per_valid_r <= 1'b1;
         else if (xfer || (wr && idx == IX_BVCLR && wb[B_PER_VALID]))
            per_valid_r <= 1'b0;
      end
   end

   // ----------------------------------------
   // compare channels
   // ----------------------------------------
   gtmr_chan_if chi [NCH] ();

   for (genvar g = 0; g < NCH; g++)
   begin : g_ch
      assign chi[g].buf_wr = lo_wr && (base == IX_CMPBUF + 6'(2 * g));
      assign chi[g].buf_data = wval;
      assign chi[g].xfer = xfer;
      assign chi[g].bv_set = wr && idx == IX_BVSET && wb[B_CMPBV + g];
      assign chi[g].bv_clr = wr && idx == IX_BVCLR && wb[B_CMPBV + g];
      assign chi[g].cnt = cnt_r;
      assign chi[g].step = upd_q_r;
      assign cmp_bv[g] = chi[g].bv;
      assign cmp_hit[g] = chi[g].hit;
      assign cmp_val[g] = chi[g].value;
      assign cmp_buf[g] = chi[g].buffer;
      gtmr_cmp_chan u_ch (
         .clock_in(clock_in),
         .reset_n_in(reset_n_in),
         .clk_en_in(clk_en_in),
         .ch(chi[g])
      );
   end

   // ----------------------------------------
   // flags and requests
   // ----------------------------------------
   // sticky, set beats clear
   always_ff @(posedge clock_in or negedge reset_n_in)
   begin
      if (!reset_n_in)
      begin
         ovf_f_r <= 1'b0;
         cmp_f_r <= '0;
      end
      else if (clk_en_in)
      begin
         ovf_f_r <= ovf_ev
            || (ovf_f_r && !(wr && idx == IX_FLAGS && wb[B_OVERFLOW]));
         cmp_f_r <= cmp_hit | (cmp_f_r
            & ~((wr && idx == IX_FLAGS) ? wb[B_CMPF +: NCH] : '0));
      end
   end

   assign ovf_irq_out = ovf_f_r && ovf_ie_r;
   assign cmp_irq_out = cmp_f_r & cmp_ie_r;

   // ----------------------------------------
   // checks
   // ----------------------------------------
   default clocking dc @(posedge clock_in); endclocking
   default disable iff (!reset_n_in);

   sequence s_rise;
      run && ev_en_r && action_r == ACT_RISING && event_in && !ev_q_r;
   endsequence

   a_lock_holds: assert property (upd_ev && lock_r && clk_en_in && !wr
      |=> per_r == $past(per_r))
      else $error("period moved while update locked");
   a_count_up: assert property (step && !down && cnt_r != top && !cnt_wr
      && clk_en_in |=> cnt_r == $past(cnt_r) + CNT_ONE)
      else $error("counter did not increment");
   a_bv_clear: assert property (clk_en_in && wr && idx == IX_BVCLR
      && wb[B_PER_VALID] && !lo_wr |=> !per_valid_r)
      else $error("valid flag not cleared");
   a_bv_set: assert property (clk_en_in && wr && idx == IX_BVSET
      && wb[B_PER_VALID] |=> per_valid_r)
      else $error("valid flag not set");
   a_per_consumed: assert property (clk_en_in && xfer && !wr
      |=> !per_valid_r && per_r == $past(per_buf_r))
      else $error("transfer did not consume period buffer");
   a_rise_step: assert property (s_rise |-> step)
      else $error("rising event not counted");
   a_cmp_hold: assert property (cmp_f_r[0] && clk_en_in
      && !(wr && idx == IX_FLAGS) |=> cmp_f_r[0])
      else $error("compare flag dropped by itself");
   a_ovf_hold: assert property (ovf_f_r && clk_en_in
      && !(wr && idx == IX_FLAGS) |=> ovf_f_r)
      else $error("overflow flag dropped by itself");
   a_break_halt: assert property (debug_halt_in && !dbg_r
      |-> !step)
      else $error("counted during break");
   a_cnt_wins: assert property (cnt_wr && clk_en_in
      |=> cnt_r == $past(wval))
      else $error("counter write lost to count");
endmodule : gtmr_top

/* verilog/gtmr_pkg.sv */
// package: constants of the general timer register and counter logic
//
// Function
// - update_lock high skips the buffer transfer; low lets it happen.
// - count_direction low counts up, high counts down; software may write it.
// - writing 1 at the valid clear address clears that buffer-valid flag.
// - writing 1 at the valid set address sets it; both read alike.
// - compare_buffer write sets its valid flag; transfer clears it.
// - period_buffer write sets period_buffer_valid; transfer clears it.
// - event action 0 steps on rising edges, action 1 on both edges.
// - event action 2 steps on prescaled ticks while the event is high.
// - event action 3 steps on ticks, up when event low, down when high.
// - event input drives counting only while event_count_enable is set.
// - enable bits 4 to 6 pass compare flags to interrupt requests.
// - enable bit 0 passes the overflow flag to its request.
// - counter reaching compare_value by a count step sets that channel's compare flag.
// - compare flag holds until software writes 1 to it.
// - overflow flag sets at top or bottom as waveform_mode selects.
// - overflow flag holds until software writes 1 to bit 0.
// - debug halt stops timer and events unless run_in_break is set.
// - one shared temporary byte serves all wide registers, also direct.
// - counter_value low byte at base, high byte at base plus one.
// - software counter write wins over a same-cycle hardware count.
// - waveform_mode picks top and whether transfer is at top or bottom.
// - buffer transfer loads every compare_value from its compare_buffer.
package gtmr_pkg;
   localparam int unsigned NCH = 3;
   localparam int unsigned CW = 16;
   // register indices; byte address is four times the index
   localparam logic [5:0] IX_CTRLA = 6'h00;
   localparam logic [5:0] IX_CTRLE = 6'h04;
   localparam logic [5:0] IX_BVCLR = 6'h06;
   localparam logic [5:0] IX_BVSET = 6'h07;
   localparam logic [5:0] IX_EVENT = 6'h09;
   localparam logic [5:0] IX_INTEN = 6'h0a;
   localparam logic [5:0] IX_FLAGS = 6'h0b;
   localparam logic [5:0] IX_DBG = 6'h0e;
   localparam logic [5:0] IX_TEMP = 6'h0f;
   localparam logic [5:0] IX_CNT = 6'h20;
   localparam logic [5:0] IX_PER = 6'h26;
   localparam logic [5:0] IX_CMP = 6'h28;
   localparam logic [5:0] IX_PER_BUF = 6'h36;
   localparam logic [5:0] IX_CMPBUF = 6'h38;
   localparam logic [5:0] IX_WIDE_MASK = 6'h3e;
   // field positions
   localparam int unsigned B_EN = 0;
   localparam int unsigned B_WGM = 1;
   localparam int unsigned B_DIR = 0;
   localparam int unsigned B_LOCK = 1;
   localparam int unsigned B_PER_VALID = 0;
   localparam int unsigned B_CMPBV = 1;
   localparam int unsigned B_EV_EN = 0;
   localparam int unsigned B_ACTION = 1;
   localparam int unsigned B_OVERFLOW = 0;
   localparam int unsigned B_CMPF = 4;
   localparam int unsigned B_RUN_BREAK = 0;
   // reset values and count step
   localparam logic [15:0] PER_RST = 16'hffff;
   localparam logic [15:0] WIDE_RST = 16'h0000;
   localparam logic [15:0] CNT_ONE = 16'h0001;
   // waveform_mode codes
   localparam logic [2:0] WG_NORMAL = 3'h0;
   localparam logic [2:0] WG_FRQ = 3'h1;
   localparam logic [2:0] WG_SINGLE = 3'h3;
   localparam logic [2:0] WG_DSTOP = 3'h5;
   localparam logic [2:0] WG_DSBOTH = 3'h6;
   localparam logic [2:0] WG_DSBOTTOM = 3'h7;
   // event_action codes
   localparam logic [1:0] ACT_RISING = 2'h0;
   localparam logic [1:0] ACT_BOTH = 2'h1;
   localparam logic [1:0] ACT_GATED = 2'h2;
   localparam logic [1:0] ACT_UPDOWN = 2'h3;
endpackage : gtmr_pkg

/* verilog/gtmr_chan_if.sv */
// interface: signals between the timer core and one compare channel
`timescale 1ns/10ps
interface gtmr_chan_if;
   logic buf_wr;
   logic [15:0] buf_data;
   logic xfer;
   logic bv_set;
   logic bv_clr;
   logic [15:0] cnt;
   logic step;
   logic bv;
   logic hit;
   logic [15:0] value;
   logic [15:0] buffer;
   modport ctl (output buf_wr, buf_data, xfer, bv_set, bv_clr, cnt, step,
      input bv, hit, value, buffer);
   modport chan (input buf_wr, buf_data, xfer, bv_set, bv_clr, cnt, step,
      output bv, hit, value, buffer);
endinterface : gtmr_chan_if

/* verilog/gtmr_cmp_chan.sv */
// one compare channel: buffer, working value, valid flag, match
`timescale 1ns/10ps
module gtmr_cmp_chan
(
   input wire logic clock_in,
   input wire logic reset_n_in,
   input wire logic clk_en_in,
   gtmr_chan_if.chan ch
);
   import gtmr_pkg::*;

   logic [15:0] buf_r;
   logic [15:0] val_r;
   logic bv_r;

   always_ff @(posedge clock_in or negedge reset_n_in)
   begin
      if (!reset_n_in)
      begin
         buf_r <= WIDE_RST;
      end
      else if (clk_en_in && ch.buf_wr)
      begin
         buf_r <= ch.buf_data;
      end
   end

   always_ff @(posedge clock_in or negedge reset_n_in)
   begin
      if (!reset_n_in)
      begin
         val_r <= WIDE_RST;
      end
      else if (clk_en_in && ch.xfer)
      begin
         val_r <= buf_r;
      end
   end

   // new buffer write wins over any clear
   always_ff @(posedge clock_in or negedge reset_n_in)
   begin
      if (!reset_n_in)
      begin
         bv_r <= 1'b0;
      end
      else if (clk_en_in)
      begin
         if (ch.buf_wr || ch.bv_set)
         begin
            bv_r <= 1'b1;
         end
         else if (ch.xfer || ch.bv_clr)
         begin
            bv_r <= 1'b0;
         end
      end
   end

   assign ch.bv = bv_r;
   assign ch.value = val_r;
   assign ch.buffer = buf_r;
   assign ch.hit = ch.step && (ch.cnt == val_r);

   a_chan_load: assert property (@(posedge clock_in) disable iff (!reset_n_in)
      (clk_en_in && ch.xfer) |=> (val_r == $past(buf_r)))
      else $error("compare value not loaded at transfer");
endmodule : gtmr_cmp_chan

/* testbench/tb.sv */
// testbench: register, counter, event and flag checks for the general timer
`timescale 1ns/10ps
module tb;
   import gtmr_pkg::*;
   logic clock_in = 1'b0;
   logic reset_n_in = 1'b0;
   logic psel = 1'b0;
   logic pen = 1'b0;
   logic pwr = 1'b0;
   logic [7:0] padr = 8'h00;
   logic [31:0] pwd = 32'h0;
   logic [31:0] prd;
   logic rdy;
   logic err;
   logic ev = 1'b0;
   logic tick = 1'b0;
   logic halt = 1'b0;
   logic ovf_irq;
   logic [2:0] cmp_irq;
   logic [31:0] rdv;
   logic slv;
   int failures = 0;
   int n_compared = 0;
   int cycles = 0;
   logic [7:0] exp_ev [5] = '{8'h11, 8'h12, 8'h11, 8'h10, 8'h12};
   logic [5:0] rst_ix [6] = '{IX_BVCLR, IX_EVENT, IX_INTEN, IX_FLAGS,
      IX_DBG, IX_TEMP};
   always #2 clock_in = ~clock_in;
   gtmr_top gtmr_top_inst (.clock_in(clock_in), .reset_n_in(reset_n_in),
      .clk_en_in(1'b1), .psel_in(psel), .penable_in(pen), .pwrite_in(pwr),
      .paddr_in(padr), .pwdata_in(pwd), .prdata_out(prd), .pready_out(rdy),
      .pslverr_out(err), .event_in(ev), .tick_in(tick),
      .debug_halt_in(halt), .ovf_irq_out(ovf_irq), .cmp_irq_out(cmp_irq));
   // ------------------------------------------------------------
   // access and compare tasks
   // ------------------------------------------------------------
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      n_compared++;
      if (g !== e)
      begin
         failures++;
         $display("wrong value at %0t: got %h expected %h", $time, g, e);
      end
   endtask : chk
   // apb transfer; waits for pready without assuming its latency
   task automatic apb(input logic w, input logic [5:0] ix,
      input logic [7:0] d);
      @(posedge clock_in);
      psel <= 1'b1;
      pen <= 1'b0;
      pwr <= w;
      padr <= {ix, 2'h0};
      pwd <= {24'h0, d};
      @(posedge clock_in);
      pen <= 1'b1;
      do
      begin
         @(posedge clock_in);
      end
      while (rdy !== 1'b1);
      rdv = prd;
      slv = err;
      psel <= 1'b0;
      pen <= 1'b0;
   endtask : apb
   task automatic wr(input logic [5:0] ix, input logic [7:0] d);
      apb(1'b1, ix, d);
   endtask : wr
   task automatic rdm(input logic [5:0] ix, input logic [31:0] e,
      input logic [31:0] m);
      apb(1'b0, ix, 8'h00);
      chk(rdv & m, e);
   endtask : rdm
   task automatic rdc(input logic [5:0] ix, input logic [31:0] e);
      rdm(ix, e, 32'hffffffff);
   endtask : rdc
   // high byte first so the low write commits both together
   task automatic ww(input logic [5:0] ix, input logic [15:0] v);
      wr(ix + 6'h01, v[15:8]);
      wr(ix, v[7:0]);
   endtask : ww
   task automatic rw(input logic [5:0] ix, input logic [15:0] v);
      rdc(ix, {24'h0, v[7:0]});
      rdc(ix + 6'h01, {24'h0, v[15:8]});
   endtask : rw
   task automatic tk(input int n);
      repeat (n)
      begin
         @(posedge clock_in);
         tick <= 1'b1;
         @(posedge clock_in);
         tick <= 1'b0;
      end
      repeat (3) @(posedge clock_in);
   endtask : tk
   task automatic evs(input logic v);
      @(posedge clock_in);
      ev <= v;
      repeat (3) @(posedge clock_in);
   endtask : evs
   task automatic wrap_up;
      $display("compared %0d, mismatches %0d", n_compared, failures);
      if (failures == 0 && n_compared > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask : wrap_up
   always @(posedge clock_in)
   begin
      cycles++;
      if (cycles == 20000)
      begin
         failures++;
         wrap_up();
      end
   end
   // ------------------------------------------------------------
   // tests
   // ------------------------------------------------------------
   initial
   begin
      repeat (12) @(posedge clock_in);
      reset_n_in <= 1'b1;
      foreach (rst_ix[i])
         rdc(rst_ix[i], 32'h0);
      rw(IX_PER, 16'hffff);
      rdc(6'h3f, 32'h0);
      chk({31'h0, slv}, 32'h1);
      wr(IX_INTEN, 8'hff);
      rdc(IX_INTEN, 32'h71);
      wr(IX_EVENT, 8'hff);
      rdc(IX_EVENT, 32'h07);
      wr(IX_DBG, 8'hff);
      rdc(IX_DBG, 32'h01);
      wr(IX_INTEN, 8'h00);
      wr(IX_EVENT, 8'h00);
      wr(IX_DBG, 8'h00);
      $display("test reset_and_reserved done");
      wr(IX_BVSET, 8'hff);
      rdc(IX_BVCLR, 32'h0f);
      wr(IX_BVCLR, 8'h05);
      rdc(IX_BVSET, 32'h0a);
      wr(IX_BVCLR, 8'h0f);
      ww(IX_CMPBUF, 16'h0002);
      rdc(IX_BVSET, 32'h02);
      ww(IX_PER_BUF, 16'h0003);
      rdc(IX_BVSET, 32'h03);
      ww(IX_CNT, 16'h1234);
      rw(IX_CNT, 16'h1234);
      rdc(IX_TEMP, 32'h12);
      wr(IX_TEMP, 8'h5a);
      rdc(IX_TEMP, 32'h5a);
      $display("test buffer_valid_and_wide done");
      ww(IX_CNT, 16'h0000);
      // period still at reset top: set it so three ticks reach it and the fourth overflows
      ww(IX_PER, 16'h0003);
      wr(IX_CTRLA, 8'h01);
      tk(4);
      rdm(IX_FLAGS, 32'h01, 32'h01);
      rw(IX_PER, 16'h0003);
      rw(IX_CMP, 16'h0002);
      rdc(IX_BVSET, 32'h00);
      wr(IX_FLAGS, 8'h71);
      rdc(IX_FLAGS, 32'h00);
      tk(2);
      rdm(IX_FLAGS, 32'h10, 32'h71);
      chk({29'h0, cmp_irq}, 32'h0);
      wr(IX_INTEN, 8'h11);
      @(negedge clock_in);
      chk({29'h0, cmp_irq}, 32'h1);
      tk(1);
      rdm(IX_FLAGS, 32'h10, 32'h10);
      wr(IX_FLAGS, 8'h10);
      rdm(IX_FLAGS, 32'h00, 32'h10);
      wr(IX_CTRLE, 8'h01);
      tk(1);
      rw(IX_CNT, 16'h0002);
      tk(3);
      chk({31'h0, ovf_irq}, 32'h1);
      $display("test count_flags_irq done");
      wr(IX_CTRLE, 8'h02);
      ww(IX_CNT, 16'h0000);
      ww(IX_CMPBUF + 6'h02, 16'h0001);
      tk(4);
      rdc(IX_BVSET, 32'h04);
      rw(IX_CMP + 6'h02, 16'h0000);
      wr(IX_CTRLE, 8'h00);
      tk(4);
      rdc(IX_BVSET, 32'h00);
      rw(IX_CMP + 6'h02, 16'h0001);
      $display("test update_lock done");
      ww(IX_PER, 16'h00ff);
      for (int a = 0; a < 5; a++)
      begin
         wr(IX_EVENT, (a < 4) ? {5'h0, a[1:0], 1'b1} : 8'h04);
         ww(IX_CNT, 16'h0010);
         evs(1'b1);
         tk(1);
         evs(1'b0);
         tk(1);
         rw(IX_CNT, {8'h00, exp_ev[a]});
      end
      $display("test event_actions done");
      wr(IX_EVENT, 8'h00);
      ww(IX_CNT, 16'h0010);
      halt <= 1'b1;
      tk(2);
      rw(IX_CNT, 16'h0010);
      wr(IX_DBG, 8'h01);
      tk(2);
      rw(IX_CNT, 16'h0012);
      halt <= 1'b0;
      $display("test debug_halt done");
      wrap_up();
   end
endmodule : tb
